// File: bts_defs.svh
// Constants for the built-in test supervisor: register offsets, fields,
// reset values and timing counts. Assumes a 100 MHz system clock.
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH

`define BTS_CLK_HZ 100000000
`define BTS_SAMPLE_S 1
`define BTS_SAMPLE_CYC (`BTS_SAMPLE_S * `BTS_CLK_HZ)
`define BTS_WDT_US 1000
`define BTS_WDT_CYC (`BTS_WDT_US * (`BTS_CLK_HZ / 1000000))
`define BTS_BUSMON_US 500
`define BTS_BUSMON_CYC (`BTS_BUSMON_US * (`BTS_CLK_HZ / 1000000))
`define BTS_RTC_US 2000
`define BTS_RTC_CYC (`BTS_RTC_US * (`BTS_CLK_HZ / 1000000))

`define BTS_A_CTRL 8'h00
`define BTS_A_STATUS 8'h04
`define BTS_A_FAULT 8'h08
`define BTS_A_AOUT 8'h0C
`define BTS_A_DOUT 8'h10
`define BTS_A_DIN_SEL 8'h14
`define BTS_A_DIN_VAL 8'h18
`define BTS_A_AIN_SEL 8'h1C
`define BTS_A_AIN_VAL 8'h20
`define BTS_A_MON0 8'h24
`define BTS_A_MONV0 8'h30
`define BTS_A_SUMMARY 8'h3C

// Control bits
`define BTS_C_START 0
`define BTS_C_FCLR 1
`define BTS_C_FREEZE 2
`define BTS_C_BLANK 3
`define BTS_C_SYSTEST 4
`define BTS_C_CDU_KICK 5
`define BTS_C_AP_KICK 6

`define BTS_FAULT_RST 16'h0000
`endif

// File: bts_pkg.sv
// Types shared by the built-in test supervisor.
// Assumes bts_defs.svh is on the include path.
package bts_pkg;
    typedef enum logic [4:0] {
        BTS_IDLE = 5'b0_0001,
        BTS_SUM = 5'b0_0010,
        BTS_RTC = 5'b0_0100,
        BTS_WRAP = 5'b0_1000,
        BTS_DONE = 5'b1_0000
    } bts_state_t;

    typedef struct packed {
        logic [7:0] proc_id;
        logic [15:0] memory_location_entry;
    } bts_mon_t;

    typedef struct packed {
        logic stability_augmentation_enable;
        logic autopilot_enable;
        logic clutch_enable;
        logic blank;
    } bts_lock_t;
endpackage : bts_pkg

// File: bts_supervisor.sv
// Built-in test supervisor: tests, monitors, maintenance and interlocks.
// Inputs synchronous to ref_clk; monitor reads answer one cycle late.
`timescale 1ns/1ns
`default_nettype none
`include "bts_defs.svh"

// Behaviour
// - Continuous in-flight checks run always, raising warnings and recording faults.
// - Automatic test starts at power-up and on software command.
// - Monitored words and measured levels refresh once per second.
// - Signal generate/measure applied only on ground with hydraulics off.
// - Discrete output addressed by low byte; value bits select discretes.
// - Low byte of discrete input address returns whole input word.
// - Three memory monitors, processor id and location, continuous or frozen.
// - Fault clear command erases stored fault code history.
// - Summary lists warnings before cautions, copied from the active inputs each cycle.
// - Display watchdog expiry blanks the display screen.
// - Autopilot processor and display declare dead bus when controller silent.
// - Bus test checks drivers send and receive all ones and zeros.
// - Power-up checksum of the first memory after load, up to mem_sum_last.
// - Power-up check that the real time clock runs.
// - System test checks each discrete output wraparound in both states.
// - Processor fault drops augmentation, autopilot and clutch enables.
// - Autopilot watchdog expiry releases augmentation and clutch.
// - Display blanked by display processor command or either watchdog.
// - Initialization page shown first, only after power-up test passes.
// - Bus controller checks its sequencing against the clock interrupt.
// - Missing valid word from any processor stores a failure.
// - Disabling failure raises a warning and forces disengagement.
module bts_supervisor #(
    parameter int SAMPLE_CYC = `BTS_SAMPLE_CYC,
    parameter int WDT_CYC = `BTS_WDT_CYC,
    parameter int BUSMON_CYC = `BTS_BUSMON_CYC,
    parameter int RTC_CYC = `BTS_RTC_CYC,
    parameter int NPROC = 4,
    parameter int NMEM = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic on_ground,
    input wire logic hydraulics_on,
    input wire logic [NPROC-1:0] proc_valid,
    input wire logic [NPROC-1:0] proc_fault,
    input wire logic bus_ctrl_tick,
    input wire logic rtc_tick,
    input wire logic seq_ok,
    input wire logic [31:0] bus_loopback,
    input wire logic mem_load_done,
    input wire logic [15:0] mem_sum_word,
    input wire logic mem_sum_last,
    input wire logic [15:0] mem_sum_expect,
    input wire logic [15:0] mem_rd_data,
    input wire logic [15:0] discrete_in,
    input wire logic [15:0] discrete_wrap,
    input wire logic [15:0] analog_in,
    input wire logic [7:0] warn_active,
    input wire logic [7:0] caution_active,
    output logic [31:0] bus_drive,
    output logic [7:0] mem_rd_proc,
    output logic [15:0] mem_rd_loc,
    output logic [15:0] aout_addr,
    output logic [15:0] aout_volt,
    output logic aout_strobe,
    output logic [7:0] dout_addr,
    output logic [15:0] dout_value,
    output logic dout_strobe,
    output logic [7:0] din_addr,
    output logic [15:0] ain_addr,
    output logic stability_augmentation_enable,
    output logic autopilot_enable,
    output logic clutch_enable,
    output logic display_blank,
    output logic init_page,
    output logic warning,
    output logic fault_clear
);
    import bts_pkg::*;
    function automatic logic [31:0] sel_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction
    bts_state_t state_q;
    logic [31:0] ctrl_q, sample_cnt_q, aout_q, dout_q;
    logic [31:0] cdu_wdt_q, ap_wdt_q, busmon_q, rtc_cnt_q;
    logic [15:0] fault_q, sum_q, ain_sel_q, din_val_q, ain_val_q, summary_q;
    logic cdu_exp_q, ap_exp_q, dead_bus_q, sum_bad_q, rtc_bad_q, wrap_bad_q;
    logic bus_bad_q, pass_q, sample_tick, safe, wr, ctl_wr, disengage;
    logic [NPROC-1:0] seen_q;
    logic [1:0] wrap_ph_q, mon_idx_q, rd_vld_q;
    logic [3:0] rd_slot_q;
    logic [7:0] din_sel_q;
    bts_mon_t mon_q [NMEM];
    logic [15:0] monv_q [NMEM];

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign ctl_wr = wr && wb_adr_i == `BTS_A_CTRL;
    assign safe = on_ground && !hydraulics_on;
    assign sample_tick = sample_cnt_q == 32'(SAMPLE_CYC - 1);
    assign disengage = |proc_fault || ap_exp_q || (|fault_q[7:0]);

    // Single-cycle ack; unmapped reads return zero, writes are dropped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_adr_i == `BTS_A_CTRL) begin
                wb_dat_o <= ctrl_q;
            end else if (wb_adr_i == `BTS_A_STATUS) begin
                wb_dat_o <= {16'h0000, 3'h0, pass_q, dead_bus_q,
                             ap_exp_q, cdu_exp_q, bus_bad_q, wrap_bad_q,
                             rtc_bad_q, sum_bad_q, state_q};
            end else if (wb_adr_i == `BTS_A_FAULT) begin
                wb_dat_o <= {16'h0000, fault_q};
            end else if (wb_adr_i == `BTS_A_AOUT) begin
                wb_dat_o <= aout_q;
            end else if (wb_adr_i == `BTS_A_DOUT) begin
                wb_dat_o <= dout_q;
            end else if (wb_adr_i == `BTS_A_DIN_SEL) begin
                wb_dat_o <= {24'h00_0000, din_sel_q};
            end else if (wb_adr_i == `BTS_A_DIN_VAL) begin
                wb_dat_o <= {16'h0000, din_val_q};
            end else if (wb_adr_i == `BTS_A_AIN_SEL) begin
                wb_dat_o <= {16'h0000, ain_sel_q};
            end else if (wb_adr_i == `BTS_A_AIN_VAL) begin
                wb_dat_o <= {16'h0000, ain_val_q};
            end else if (wb_adr_i >= `BTS_A_MON0 &&
                         wb_adr_i < `BTS_A_MONV0) begin
                wb_dat_o <= {8'h00, mon_q[2'(wb_adr_i[7:2] - 6'd9)]};
            end else if (wb_adr_i >= `BTS_A_MONV0 &&
                         wb_adr_i < `BTS_A_SUMMARY) begin
                wb_dat_o <= {16'h0000, monv_q[2'(wb_adr_i[7:2] - 6'd12)]};
            end else if (wb_adr_i == `BTS_A_SUMMARY) begin
                wb_dat_o <= {16'h0000, summary_q};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 32'h0000_0000;
        end else if (ctl_wr) begin
            ctrl_q <= sel_merge(ctrl_q, wb_dat_i, wb_sel_i);
        end else begin
            // Command bits are self-clearing strobes; freeze and blank stay
            ctrl_q <= ctrl_q & 32'h0000_000C;
        end
    end

    // One-second sample enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_cnt_q <= 32'h0000_0000;
        end else begin
            sample_cnt_q <= sample_tick ? '0 : sample_cnt_q + 32'h0000_0001;
        end
    end

    // Power-up and commanded test sequence
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= BTS_SUM;
            sum_q <= 16'h0000;
            sum_bad_q <= 1'b0;
            rtc_bad_q <= 1'b0;
            wrap_bad_q <= 1'b0;
            pass_q <= 1'b0;
            rtc_cnt_q <= 32'h0000_0000;
            wrap_ph_q <= 2'b00;
        end else begin
            case (state_q)
                BTS_IDLE, BTS_DONE: begin
                    if (ctrl_q[`BTS_C_START]) begin
                        state_q <= BTS_SUM;
                        sum_q <= 16'h0000;
                        pass_q <= 1'b0;
                    end else if (ctrl_q[`BTS_C_SYSTEST]) begin
                        state_q <= BTS_WRAP;
                        wrap_ph_q <= 2'b00;
                    end
                end
                BTS_SUM: begin
                    if (mem_load_done) begin
                        sum_q <= sum_q + mem_sum_word;
                        if (mem_sum_last) begin
                            sum_bad_q <= (sum_q + mem_sum_word) !=
                                         mem_sum_expect;
                            rtc_cnt_q <= 32'h0000_0000;
                            state_q <= BTS_RTC;
                        end
                    end
                end
                BTS_RTC: begin
                    rtc_cnt_q <= rtc_cnt_q + 32'h0000_0001;
                    if (rtc_tick) begin
                        rtc_bad_q <= 1'b0;
                        pass_q <= !sum_bad_q;
                        state_q <= BTS_DONE;
                    end else if (rtc_cnt_q == 32'(RTC_CYC - 1)) begin
                        rtc_bad_q <= 1'b1;
                        state_q <= BTS_DONE;
                    end
                end
                BTS_WRAP: begin
                    wrap_ph_q <= wrap_ph_q + 2'b01;
                    if (wrap_ph_q == 2'b01 && discrete_wrap != 16'hFFFF) begin
                        wrap_bad_q <= 1'b1;
                    end
                    if (wrap_ph_q == 2'b11) begin
                        wrap_bad_q <= wrap_bad_q || discrete_wrap != '0;
                        state_q <= BTS_DONE;
                    end
                end
                default: state_q <= BTS_IDLE;
            endcase
        end
    end

    // Watchdogs and bus monitor; watchdog expiry latches until reset, dead bus clears on a controller tick before expiry, not the first after silence
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cdu_wdt_q <= 32'h0000_0000;
            ap_wdt_q <= 32'h0000_0000;
            busmon_q <= 32'h0000_0000;
            cdu_exp_q <= 1'b0;
            ap_exp_q <= 1'b0;
            dead_bus_q <= 1'b0;
        end else begin
            cdu_wdt_q <= ctrl_q[`BTS_C_CDU_KICK] ? '0 : cdu_wdt_q + 32'h1;
            ap_wdt_q <= ctrl_q[`BTS_C_AP_KICK] ? '0 : ap_wdt_q + 32'h1;
            busmon_q <= bus_ctrl_tick ? '0 : busmon_q + 32'h1;
            if (cdu_wdt_q >= 32'(WDT_CYC - 1)) begin
                cdu_exp_q <= 1'b1;
            end
            if (ap_wdt_q >= 32'(WDT_CYC - 1)) begin
                ap_exp_q <= 1'b1;
            end
            if (busmon_q >= 32'(BUSMON_CYC - 1)) begin
                dead_bus_q <= 1'b1;
            end else if (bus_ctrl_tick) begin
                dead_bus_q <= 1'b0;
            end
        end
    end

    // Continuous in-flight monitoring and fault storage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= `BTS_FAULT_RST;
            seen_q <= '0;
            bus_bad_q <= 1'b0;
            bus_drive <= 32'h0000_0000;
        end else begin
            bus_drive <= ~bus_drive;
            if (bus_loopback != bus_drive) begin
                bus_bad_q <= 1'b1;
            end
            seen_q <= sample_tick ? '0 : (seen_q | proc_valid);
            // New faults beat a clear in the same cycle
            fault_q <= (ctrl_q[`BTS_C_FCLR] ? 16'h0000 : fault_q) |
                {8'h00, dead_bus_q, !seq_ok, bus_bad_q, |proc_fault,
                 sample_tick && seen_q != {NPROC{1'b1}},
                 ap_exp_q, cdu_exp_q, sum_bad_q | rtc_bad_q};
        end
    end

    // Maintenance signal generation and measurement
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aout_q <= 32'h0000_0000;
            dout_q <= 32'h0000_0000;
            din_sel_q <= 8'h00;
            ain_sel_q <= 16'h0000;
            din_val_q <= 16'h0000;
            ain_val_q <= 16'h0000;
            aout_strobe <= 1'b0;
            dout_strobe <= 1'b0;
            aout_addr <= 16'h0000;
            aout_volt <= 16'h0000;
            dout_addr <= 8'h00;
            dout_value <= 16'h0000;
            din_addr <= 8'h00;
            ain_addr <= 16'h0000;
        end else begin
            aout_strobe <= 1'b0;
            dout_strobe <= 1'b0;
            if (wr && wb_adr_i == `BTS_A_AOUT && safe) begin
                aout_q <= sel_merge(aout_q, wb_dat_i, wb_sel_i);
                aout_addr <= wb_dat_i[31:16];
                aout_volt <= wb_dat_i[15:0];
                aout_strobe <= 1'b1;
            end
            if (wr && wb_adr_i == `BTS_A_DOUT && safe) begin
                dout_q <= sel_merge(dout_q, wb_dat_i, wb_sel_i);
                dout_addr <= wb_dat_i[23:16];
                dout_value <= wb_dat_i[15:0];
                dout_strobe <= 1'b1;
            end
            if (state_q == BTS_WRAP) begin
                dout_value <= {16{!wrap_ph_q[1]}};
            end
            if (wr && wb_adr_i == `BTS_A_DIN_SEL && safe) begin
                din_sel_q <= wb_dat_i[7:0];
                din_addr <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == `BTS_A_AIN_SEL && safe) begin
                ain_sel_q <= wb_dat_i[15:0];
                ain_addr <= wb_dat_i[15:0];
            end
            if (sample_tick && safe) begin
                din_val_q <= discrete_in;
                ain_val_q <= analog_in;
            end
        end
    end

    // Memory monitors: one read per slot, all refreshed each second unless frozen
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_idx_q <= 2'b11;
            rd_vld_q <= 2'b00;
            rd_slot_q <= 4'h0;
            mem_rd_proc <= 8'h00;
            mem_rd_loc <= 16'h0000;
            for (int i = 0; i < NMEM; i++) begin
                mon_q[i] <= '0;
                monv_q[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < NMEM; i++) begin
                if (wr && wb_adr_i == 8'(`BTS_A_MON0 + 4 * i)) begin
                    mon_q[i] <= wb_dat_i[23:0];
                end
            end
            if (sample_tick && !ctrl_q[`BTS_C_FREEZE]) begin
                mon_idx_q <= 2'b00;
            end else if (mon_idx_q < 2'(NMEM)) begin
                mon_idx_q <= mon_idx_q + 2'b01;
            end
            if (mon_idx_q < 2'(NMEM)) begin
                mem_rd_proc <= mon_q[mon_idx_q].proc_id;
                mem_rd_loc <= mon_q[mon_idx_q].memory_location_entry;
            end
            // Data answers one cycle after the registered address
            rd_vld_q <= {rd_vld_q[0], mon_idx_q < 2'(NMEM)};
            rd_slot_q <= {rd_slot_q[1:0], mon_idx_q};
            if (rd_vld_q[1]) begin
                monv_q[rd_slot_q[3:2]] <= mem_rd_data;
            end
        end
    end

    // Interlocks and summary
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stability_augmentation_enable <= 1'b0;
            autopilot_enable <= 1'b0;
            clutch_enable <= 1'b0;
            display_blank <= 1'b1;
            init_page <= 1'b0;
            warning <= 1'b0;
            fault_clear <= 1'b0;
            summary_q <= 16'h0000;
        end else begin
            stability_augmentation_enable <= !disengage;
            autopilot_enable <= !disengage;
            clutch_enable <= !disengage;
            display_blank <= ctrl_q[`BTS_C_BLANK] || cdu_exp_q ||
                             ap_exp_q || dead_bus_q;
            init_page <= pass_q && state_q == BTS_DONE;
            warning <= disengage || |fault_q;
            fault_clear <= ctrl_q[`BTS_C_FCLR];
            summary_q <= {warn_active, caution_active};
        end
    end
endmodule // bts_supervisor
`default_nettype wire

// File: bts_supervisor_assertions.sv
// Port-level checker for the built-in test supervisor.
// Bound to every bts_supervisor; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module bts_checker #(parameter int NPROC = 4) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic on_ground,
    input wire logic hydraulics_on,
    input wire logic [NPROC-1:0] proc_fault,
    input wire logic [31:0] bus_drive,
    input wire logic aout_strobe,
    input wire logic dout_strobe,
    input wire logic stability_augmentation_enable,
    input wire logic autopilot_enable,
    input wire logic clutch_enable,
    input wire logic init_page,
    input wire logic warning,
    input wire logic fault_clear
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] up_q;
    wire logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic ctrl_wr = taken && wb_we_i && wb_adr_i == 8'h00;
    wire logic engaged = stability_augmentation_enable || autopilot_enable
        || clutch_enable;
    // Counts cycles since reset, saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) up_q <= 4'h0;
        else if (up_q != 4'hF) up_q <= up_q + 4'h1;
    end
    AST_ACK_ONE: assert property (taken |=> wb_ack_o)
        else $error("ack missing");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    AST_AOUT_GATE: assert property (aout_strobe |->
        $past(on_ground) && !$past(hydraulics_on))
        else $error("analog output off ground");
    AST_DOUT_GATE: assert property (dout_strobe |->
        $past(on_ground) && !$past(hydraulics_on))
        else $error("discrete output off ground");
    AST_FAULT_DISENG: assert property (|proc_fault |-> ##[1:4] !engaged)
        else $error("engaged during fault");
    AST_WARN_DISENG: assert property ($rose(warning) |-> ##[0:2]
        (!autopilot_enable && !clutch_enable))
        else $error("no disengage");
    AST_BUS_TOGGLE: assert property ($past(rst_n) |->
        bus_drive == ~$past(bus_drive) && (bus_drive == '0 || bus_drive == '1))
        else $error("bus pattern");
    AST_FCLR_CAUSE: assert property (fault_clear |->
        ($past(ctrl_wr) || $past(ctrl_wr, 2)) ##1 !fault_clear)
        else $error("stray fault clear");
    AST_INIT_LATE: assert property (init_page |-> up_q > 4'h3)
        else $error("early init page");
    cover property (aout_strobe);
    cover property ($rose(init_page));
    cover property (fault_clear);
endmodule // bts_checker

bind bts_supervisor bts_checker #(.NPROC(NPROC)) i_chk (.*);
`default_nettype wire

// File: bts_far_model.sv
// Far side of the supervisor: processors, bus controller, clock, loader.
// Assumes the supervisor samples these on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module bts_far_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic silent,
    input wire logic [31:0] bus_drive,
    input wire logic [7:0] mem_rd_proc,
    input wire logic [15:0] mem_rd_loc,
    input wire logic [15:0] dout_value,
    output logic [3:0] proc_valid,
    output logic bus_ctrl_tick,
    output logic rtc_tick,
    output logic seq_ok,
    output logic [31:0] bus_loopback,
    output logic mem_load_done,
    output logic [15:0] mem_sum_word,
    output logic mem_sum_last,
    output logic [15:0] mem_sum_expect,
    output logic [15:0] mem_rd_data,
    output logic [15:0] discrete_wrap
);
    logic [3:0] tick_q;
    logic [4:0] word_q;
    assign bus_loopback = bus_drive;
    assign discrete_wrap = dout_value;
    assign seq_ok = 1'h1;
    // Silence stops both valid words and controller traffic
    assign proc_valid = {4{tick_q[2:0] == 3'h0 && !silent}};
    assign bus_ctrl_tick = proc_valid[0];
    assign rtc_tick = tick_q == 4'hF;
    // Three memories of four words; expect is each memory's total
    assign mem_load_done = word_q < 5'h0C;
    assign mem_sum_word = 16'h0101 * {11'h0, word_q};
    assign mem_sum_last = word_q[1:0] == 2'h3;
    assign mem_sum_expect = 16'h0101 * {10'h0, word_q[3:2], 4'h6};
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 4'h0;
            word_q <= 5'h0;
        end else begin
            tick_q <= tick_q + 4'h1;
            if (mem_load_done) word_q <= word_q + 5'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        mem_rd_data <= mem_rd_loc ^ {mem_rd_proc, 8'h5A};
    end
endmodule // bts_far_model
`default_nettype wire

// File: bts_supervisor_tb.sv
// Self-checking bench for the built-in test supervisor.
// Drives Wishbone, ground state and faults; far side is bts_far_model.
`timescale 1ns/1ns
`default_nettype none
module bts_supervisor_tb;
    localparam int SMP = 100;
    localparam int WDT = 600;
    logic ref_clk = '0, rst_n = '0, wb_cyc_i = '0, wb_stb_i = '0;
    logic wb_we_i = '0, on_ground = '1, hydraulics_on = '0, silent = '0;
    logic [7:0] wb_adr_i = '0, warn_active = '0, caution_active = '0;
    logic [3:0] wb_sel_i = 4'hF, proc_fault = '0, proc_valid;
    logic [31:0] wb_dat_i = '0, wb_dat_o, bus_drive, bus_loopback, q;
    logic [15:0] discrete_in = '0, analog_in = '0, mem_sum_word;
    logic [15:0] mem_sum_expect, mem_rd_data, discrete_wrap, mem_rd_loc;
    logic [15:0] aout_addr, aout_volt, dout_value, ain_addr;
    logic [7:0] mem_rd_proc, dout_addr, din_addr;
    logic wb_ack_o, bus_ctrl_tick, rtc_tick, seq_ok, mem_load_done;
    logic mem_sum_last, aout_strobe, dout_strobe, autopilot_enable;
    logic stability_augmentation_enable, clutch_enable, display_blank;
    logic init_page, warning, fault_clear;
    int fail_count = 0, tests_run = 0, na = 0, nd = 0;
    bts_supervisor #(.SAMPLE_CYC(SMP), .WDT_CYC(WDT), .BUSMON_CYC(40),
        .RTC_CYC(30)) i_dut (.*);
    bts_far_model i_far (.*);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (aout_strobe === 1'h1) na++;
        if (dout_strobe === 1'h1) nd++;
    end
    function automatic logic gate(input logic g, input logic h);
        return g && !h;
    endfunction
    function automatic logic [15:0] mon_exp(input logic [7:0] p,
            input logic [15:0] l);
        return l ^ {p, 8'h5A};
    endfunction
    task automatic conclude;
        $display("mismatches %0d, checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Classic cycle: hold the request until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        wb_cyc_i <= '1;
        wb_stb_i <= '1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= '0;
        wb_stb_i <= '0;
        if (n >= 50) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic kick(input logic [31:0] c);
        wb('1, 8'h00, c);
    endtask
    initial begin
        int n, m;
        logic [31:0] v, w;
        logic [7:0] p[3];
        logic [15:0] l[3];
        void'($urandom(24517));
        repeat (10) @(posedge ref_clk);
        chk(32'(display_blank), 32'h1, "blank in reset");
        rst_n <= '1;
        for (n = 0; n < 3000 && init_page !== 1'h1; n++) @(posedge ref_clk);
        chk(32'(init_page), 32'h1, "init page");
        wb('0, 8'h04, '0);
        chk(32'(q[12]), 32'h1, "power-up pass");
        wb('0, 8'hFC, '0);
        chk(q, 32'h0, "unmapped read");
        for (int i = 0; i < 6; i++) begin
            kick(32'h60);
            hydraulics_on <= (i % 3 == 2);
            on_ground <= (i != 4);
            v = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            w = ~v;
            n = na;
            m = nd;
            wb('1, 8'h0C, v);
            wb('1, 8'h10, w);
            repeat (3) @(posedge ref_clk);
            chk(na - n, 32'(gate(on_ground, hydraulics_on)), "aout");
            chk(nd - m, 32'(gate(on_ground, hydraulics_on)), "dout");
            if (gate(on_ground, hydraulics_on)) begin
                chk({aout_addr, aout_volt}, v, "aout data");
                chk({dout_addr, dout_value}, w[23:0], "dout data");
            end
        end
        on_ground <= '1;
        hydraulics_on <= '0;
        discrete_in <= $urandom;
        v = $urandom;
        wb('1, 8'h14, {24'h0, v[7:0]});
        for (int k = 0; k < 3; k++) begin
            p[k] = $urandom;
            l[k] = $urandom;
            wb('1, 8'h24 + 8'(4 * k), {8'h0, p[k], l[k]});
        end
        repeat (2 * SMP + 10) @(posedge ref_clk);
        chk(32'(din_addr), 32'(v[7:0]), "din addr");
        wb('0, 8'h18, '0);
        chk(32'(q[15:0]), 32'(discrete_in), "din value");
        for (int k = 0; k < 3; k++) begin
            wb('0, 8'h30 + 8'(4 * k), '0);
            chk(32'(q[15:0]), 32'(mon_exp(p[k], l[k])), "monitor");
        end
        kick(32'h64);
        wb('1, 8'h24, {8'h0, p[0], ~l[0]});
        repeat (2 * SMP + 10) @(posedge ref_clk);
        wb('0, 8'h30, '0);
        chk(32'(q[15:0]), 32'(mon_exp(p[0], l[0])), "frozen");
        kick(32'h60);
        proc_fault <= 4'h1;
        repeat (6) @(posedge ref_clk);
        chk(32'(warning), 32'h1, "warning");
        wb('0, 8'h08, '0);
        chk(32'(q[4]), 32'h1, "fault stored");
        proc_fault <= 4'h0;
        kick(32'h62);
        wb('0, 8'h08, '0);
        chk(q, 32'h0, "fault cleared");
        kick(32'h70);
        repeat (8) @(posedge ref_clk);
        wb('0, 8'h04, '0);
        chk(32'(q[7:0]), 32'h10, "wraparound");
        silent <= '1;
        repeat (2 * SMP) @(posedge ref_clk);
        wb('0, 8'h04, '0);
        chk(32'(q[11]), 32'h1, "dead bus");
        wb('0, 8'h08, '0);
        chk(32'(q[3]), 32'h1, "missing valid");
        silent <= '0;
        repeat (WDT + 20) @(posedge ref_clk);
        kick(32'h60);
        repeat (5) @(posedge ref_clk);
        chk({31'h0, display_blank}, 32'h1, "wdt blank latched");
        chk(32'(stability_augmentation_enable | clutch_enable), 32'h0,
            "wdt release");
        conclude();
    end
endmodule // bts_supervisor_tb
`default_nettype wire
